//--- logic/oscsel_pkg.sv
// Purpose: constants and types for the oscillator and clock select block
// Assumes: special-function register port with 8-bit address and data
// Notes: trim value is a parameter of the top module
package oscsel_pkg;
  localparam logic [7:0] ADDR_OSC_CONTROL = 8'hB2;
  localparam logic [7:0] ADDR_OSC_CALIBRATION = 8'hB3;
  localparam logic [7:0] ADDR_LFO_CONTROL = 8'h86;
  localparam logic [7:0] ADDR_CLK_SELECT = 8'hA9;
  localparam logic [7:0] ADDR_MULT_CONTROL = 8'hB9;
  localparam logic [7:0] RST_OSC_CONTROL = 8'hC0;
  localparam logic [7:0] RST_LFO_CONTROL = 8'h00;
  localparam logic [7:0] RST_CLK_SELECT = 8'h00;
  localparam logic [7:0] RST_MULT_CONTROL = 8'h00;
  localparam int BIT_OSC_ENABLE = 7;
  localparam int BIT_OSC_READY = 6;
  localparam int BIT_OSC_SUSPEND = 5;
  localparam logic [1:0] DIV_BY_8 = 2'h3;
  localparam int CAL_WIDTH = 7;
  localparam int MULT_FACTOR = 4;
  localparam logic [7:0] MULT_INIT_BITS = 8'hC0;
  localparam logic [2:0] OSC_SETTLE_CYCLES = 3'h4;
  localparam logic [1:0] MULT_LOCK_CYCLES = 2'h3;
  typedef enum logic [1:0] {
    OSCSEL_SYS_INTERNAL = 2'h0,
    OSCSEL_SYS_EXTERNAL = 2'h1,
    OSCSEL_SYS_MULT_HALF = 2'h2,
    OSCSEL_SYS_LOW_FREQ = 2'h3
  } oscsel_sys_src_t;
  typedef enum logic [1:0] {
    OSCSEL_USB_MULT = 2'h0,
    OSCSEL_USB_EXTERNAL = 2'h1,
    OSCSEL_USB_INT_HALF = 2'h2,
    OSCSEL_USB_RSVD = 2'h3
  } oscsel_usb_src_t;
  typedef enum logic [1:0] {
    OSCSEL_OSC_OFF = 2'h0,
    OSCSEL_OSC_SETTLE = 2'h1,
    OSCSEL_OSC_RUN = 2'h2,
    OSCSEL_OSC_SUSP = 2'h3
  } oscsel_osc_state_t;
endpackage

//--- logic/oscsel_mux_if.sv
// Purpose: carries the clock-enable selection between top and switch
// Assumes: one system clock domain
// Notes: none
`timescale 1ns/10ps
interface oscsel_mux_if;
  import oscsel_pkg::*;
  logic [3:0] src_tick;
  logic [1:0] sel;
  logic out_tick;
  logic busy;
  modport top (output src_tick, output sel, input out_tick, input busy);
  modport sw (input src_tick, input sel, output out_tick, output busy);
endinterface

//--- logic/oscsel_switch.sv
// Purpose: glitch-free switch among four clock-enable streams
// Assumes: sources are ticks on i_clk
// Notes: breaks old source, waits a tick of new one, then follows it
`timescale 1ns/10ps
module oscsel_switch
  import oscsel_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // selection
  oscsel_mux_if.sw mux
);
  logic [1:0] cur;
  logic gap;
  // during a change the output is held quiet until the new source ticks
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cur <= 2'h0;
      gap <= 1'b0;
    end else if (mux.sel != cur && !gap) begin
      gap <= 1'b1;
    end else if (gap && mux.src_tick[mux.sel]) begin
      cur <= mux.sel;
      gap <= 1'b0;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      mux.out_tick <= 1'b0;
    end else begin
      mux.out_tick <= !gap && mux.sel == cur && mux.src_tick[cur];
    end
  end
  assign mux.busy = gap;
  a_switch_quiet: assert property (@(posedge i_clk) disable iff (i_srst)
    gap |=> !mux.out_tick) else $error("tick leaked during switch");
endmodule

//--- logic/oscsel_top.sv
// Purpose: internal oscillator control, divider and clock source selection
// Assumes: oscillators modelled as enables on i_clk; pins pass two flops
// Notes: clocks leave as one-cycle tick enables
`timescale 1ns/10ps
// Overview of operation
// - system clock defaults to internal oscillator
// - system sources internal, external, low-freq, multiplier/2
// - usb sources internal/2, external, multiplier
// - calibration resets to factory 12 MHz trim
// - internal oscillator divided by 1,2,4,8
// - divider resets to divide-by-eight
// - software writes calibration trim field
// - every reset restores factory trim value
// - writing suspend one stops internal oscillator
// - usb activity or vbus match restarts oscillator
// - registers enable, disable, calibrate internal oscillator
// - separate register controls low-frequency oscillator
// - multiplier turns 12 MHz into 48 MHz
module oscsel_top
  import oscsel_pkg::*;
#(
  parameter logic [6:0] FACTORY_TRIM = 7'h40
)(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // special-function register port
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  // oscillator raw ticks
  input wire logic i_int_osc_tick,
  input wire logic i_ext_clk_tick,
  input wire logic i_lfo_tick,
  input wire logic i_mult_tick,
  // wake sources
  input wire logic i_usb_activity,
  input wire logic i_vbus_level,
  input wire logic i_bus_power_polarity_select,
  // oscillator controls
  output logic o_int_osc_run,
  output logic [6:0] o_period_trim,
  output logic [7:0] o_low_freq_osc_control,
  output logic [7:0] o_multiplier_control,
  // clock enables
  output logic o_system_clock_tick,
  output logic o_usb_bus_clock_tick,
  output logic o_switch_busy
);
  oscsel_mux_if sys_mux();
  logic [1:0] internal_clock_divider;
  logic internal_osc_enable;
  logic suspend_req;
  logic [6:0] period_trim;
  logic [7:0] low_freq_osc_control;
  logic [7:0] clock_select;
  logic [7:0] multiplier_control;
  logic [2:0] div_cnt;
  logic usb_half;
  logic mult_half;
  logic [2:0] settle;
  logic [1:0] mult_lock;
  logic [3:0] s1;
  logic [3:0] s2;
  logic [2:0] w1;
  logic [2:0] w2;
  logic wake;
  oscsel_osc_state_t osc_state;
  oscsel_osc_state_t next_osc_state;

  function automatic logic div_hit(input logic [2:0] cnt, input logic [1:0] sel);
    div_hit = (cnt & ((3'h1 << sel) - 3'h1)) == 3'h0;
  endfunction

  function automatic logic sel_wr(input logic [7:0] addr, input logic [7:0] target, input logic wr);
    sel_wr = wr && addr == target;
  endfunction

  // pins and oscillator ticks are asynchronous to i_clk
  always_ff @(posedge i_clk) begin
    s1 <= {i_mult_tick, i_lfo_tick, i_ext_clk_tick, i_int_osc_tick};
    s2 <= s1;
    w1 <= {i_bus_power_polarity_select, i_vbus_level, i_usb_activity};
    w2 <= w1;
  end
  assign wake = w2[0] || (w2[1] == w2[2]);

  // internal oscillator control register
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      internal_osc_enable <= RST_OSC_CONTROL[BIT_OSC_ENABLE];
      internal_clock_divider <= DIV_BY_8;
    end else if (sel_wr(i_sfr_addr, ADDR_OSC_CONTROL, i_sfr_wr)) begin
      internal_osc_enable <= i_sfr_wdata[BIT_OSC_ENABLE];
      internal_clock_divider <= i_sfr_wdata[1:0];
    end
  end

  // suspend request is a one-cycle strobe from a write of one
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      suspend_req <= 1'b0;
    end else begin
      suspend_req <= sel_wr(i_sfr_addr, ADDR_OSC_CONTROL, i_sfr_wr) && i_sfr_wdata[BIT_OSC_SUSPEND];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      period_trim <= FACTORY_TRIM;
    end else if (sel_wr(i_sfr_addr, ADDR_OSC_CALIBRATION, i_sfr_wr)) begin
      period_trim <= i_sfr_wdata[CAL_WIDTH-1:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      low_freq_osc_control <= RST_LFO_CONTROL;
    end else if (sel_wr(i_sfr_addr, ADDR_LFO_CONTROL, i_sfr_wr)) begin
      low_freq_osc_control <= i_sfr_wdata;
    end
  end

  // clock select: [1:0] system source, [5:4] usb source
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      clock_select <= RST_CLK_SELECT;
    end else if (sel_wr(i_sfr_addr, ADDR_CLK_SELECT, i_sfr_wr)) begin
      clock_select <= i_sfr_wdata & 8'h33;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      multiplier_control <= RST_MULT_CONTROL;
    end else if (sel_wr(i_sfr_addr, ADDR_MULT_CONTROL, i_sfr_wr)) begin
      multiplier_control <= i_sfr_wdata;
    end
  end

  // oscillator state; suspend holds until a wake event
  always_comb begin
    next_osc_state = osc_state;
    unique case (osc_state)
      OSCSEL_OSC_OFF: if (internal_osc_enable) next_osc_state = OSCSEL_OSC_SETTLE;
      OSCSEL_OSC_SETTLE: begin
        if (!internal_osc_enable) next_osc_state = OSCSEL_OSC_OFF;
        else if (suspend_req) next_osc_state = OSCSEL_OSC_SUSP;
        else if (settle == OSC_SETTLE_CYCLES) next_osc_state = OSCSEL_OSC_RUN;
      end
      OSCSEL_OSC_RUN: begin
        if (!internal_osc_enable) next_osc_state = OSCSEL_OSC_OFF;
        else if (suspend_req) next_osc_state = OSCSEL_OSC_SUSP;
      end
      OSCSEL_OSC_SUSP: if (wake) next_osc_state = OSCSEL_OSC_SETTLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      osc_state <= OSCSEL_OSC_SETTLE;
      settle <= 3'h0;
    end else begin
      osc_state <= next_osc_state;
      settle <= (osc_state == OSCSEL_OSC_SETTLE && settle != OSC_SETTLE_CYCLES) ? settle + 3'h1 : 3'h0;
    end
  end

  // multiplier lock: counts its input ticks after init
  always_ff @(posedge i_clk) begin
    if (i_srst || multiplier_control[7:6] != MULT_INIT_BITS[7:6]) begin
      mult_lock <= 2'h0;
    end else if (s2[3] && mult_lock != MULT_LOCK_CYCLES) begin
      mult_lock <= mult_lock + 2'h1;
    end
  end

  // divider and halving counters run on their source ticks
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      div_cnt <= 3'h0;
      usb_half <= 1'b0;
      mult_half <= 1'b0;
    end else begin
      if (s2[0] && osc_state == OSCSEL_OSC_RUN) begin
        div_cnt <= div_cnt + 3'h1;
        usb_half <= ~usb_half;
      end
      if (s2[3]) begin
        mult_half <= ~mult_half;
      end
    end
  end

  assign sys_mux.sel = clock_select[1:0];
  assign sys_mux.src_tick[OSCSEL_SYS_INTERNAL] = s2[0] && osc_state == OSCSEL_OSC_RUN
    && div_hit(div_cnt, internal_clock_divider);
  assign sys_mux.src_tick[OSCSEL_SYS_EXTERNAL] = s2[1];
  assign sys_mux.src_tick[OSCSEL_SYS_MULT_HALF] = s2[3] && mult_half;
  assign sys_mux.src_tick[OSCSEL_SYS_LOW_FREQ] = s2[2] && low_freq_osc_control[7];

  oscsel_switch u_sys_switch (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .mux(sys_mux)
  );

  // usb clock select; trimmed internal source is software's burden
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_usb_bus_clock_tick <= 1'b0;
    end else begin
      unique case (oscsel_usb_src_t'(clock_select[5:4]))
        OSCSEL_USB_MULT: o_usb_bus_clock_tick <= s2[3] && mult_lock == MULT_LOCK_CYCLES;
        OSCSEL_USB_EXTERNAL: o_usb_bus_clock_tick <= s2[1];
        OSCSEL_USB_INT_HALF: o_usb_bus_clock_tick <= s2[0] && osc_state == OSCSEL_OSC_RUN && usb_half;
        OSCSEL_USB_RSVD: o_usb_bus_clock_tick <= 1'b0;
      endcase
    end
  end

  // read data; ready bit reflects state only
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_sfr_rd) begin
      unique case (i_sfr_addr)
        ADDR_OSC_CONTROL: o_sfr_rdata <= {internal_osc_enable, osc_state == OSCSEL_OSC_RUN, 4'h0,
          internal_clock_divider};
        ADDR_OSC_CALIBRATION: o_sfr_rdata <= {1'b0, period_trim};
        ADDR_LFO_CONTROL: o_sfr_rdata <= low_freq_osc_control;
        ADDR_CLK_SELECT: o_sfr_rdata <= clock_select;
        ADDR_MULT_CONTROL: o_sfr_rdata <= {multiplier_control[7:6], mult_lock == MULT_LOCK_CYCLES,
          multiplier_control[4:0]};
        default: o_sfr_rdata <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_int_osc_run <= 1'b0;
      o_period_trim <= FACTORY_TRIM;
      o_low_freq_osc_control <= RST_LFO_CONTROL;
      o_multiplier_control <= RST_MULT_CONTROL;
      o_system_clock_tick <= 1'b0;
      o_switch_busy <= 1'b0;
    end else begin
      o_int_osc_run <= osc_state == OSCSEL_OSC_RUN || osc_state == OSCSEL_OSC_SETTLE;
      o_period_trim <= period_trim;
      o_low_freq_osc_control <= low_freq_osc_control;
      o_multiplier_control <= multiplier_control;
      o_system_clock_tick <= sys_mux.out_tick;
      o_switch_busy <= sys_mux.busy;
    end
  end

  sequence seq_susp_write;
    suspend_req && osc_state == OSCSEL_OSC_RUN && internal_osc_enable;
  endsequence
  sequence seq_stopped;
    osc_state == OSCSEL_OSC_SUSP ##1 !o_int_osc_run;
  endsequence

  a_reset_divider: assert property (@(posedge i_clk) $fell(i_srst) |-> internal_clock_divider == DIV_BY_8
    && clock_select[1:0] == 2'h0) else $error("divider not eight after reset");
  a_trim_restore: assert property (@(posedge i_clk) $fell(i_srst) |-> period_trim == FACTORY_TRIM)
    else $error("trim not restored");
  a_suspend_stops: assert property (@(posedge i_clk) disable iff (i_srst) seq_susp_write |=> seq_stopped)
    else $error("suspend did not stop oscillator");
  a_wake_restarts: assert property (@(posedge i_clk) disable iff (i_srst)
    osc_state == OSCSEL_OSC_SUSP && wake |=> osc_state == OSCSEL_OSC_SETTLE) else $error("no wake");
  a_ready_flag: assert property (@(posedge i_clk) disable iff (i_srst)
    i_sfr_rd && i_sfr_addr == ADDR_OSC_CONTROL |=> o_sfr_rdata[BIT_OSC_READY] == $past(osc_state == OSCSEL_OSC_RUN))
    else $error("ready flag wrong");
  a_trim_write: assert property (@(posedge i_clk) disable iff (i_srst)
    i_sfr_wr && i_sfr_addr == ADDR_OSC_CALIBRATION |=> ##1 o_period_trim == $past(i_sfr_wdata[6:0], 2))
    else $error("trim write lost");
  a_div_gate: assert property (@(posedge i_clk) disable iff (i_srst)
    sys_mux.src_tick[0] |-> osc_state == OSCSEL_OSC_RUN) else $error("internal tick while stopped");
  a_run_after_reset: assert property (@(posedge i_clk) $fell(i_srst) |-> ##[1:6] osc_state == OSCSEL_OSC_RUN)
    else $error("oscillator not running after reset");
endmodule

//--- bench/tb_oscsel_top.sv
// Purpose: self-checking bench for the oscillator and clock select block
// Assumes: raw ticks int/2, ext/3, lfo/7, mult/5 cycles; divider codes 0..3 give /1../8
// Notes: tick spacing compared with a small model; reset bits 7:6 checked, divider by spacing
`timescale 1ns/10ps
module tb_oscsel_top;
  import oscsel_pkg::*;
  localparam logic [6:0] TRIM = 7'h40;
  localparam int LIMIT = 20000;
  logic i_clk = 0;
  logic i_srst = 1;
  logic i_sfr_wr = 0;
  logic i_sfr_rd = 0;
  logic [7:0] i_sfr_addr = 8'h00;
  logic [7:0] i_sfr_wdata = 8'h00;
  logic i_int_osc_tick = 0;
  logic i_ext_clk_tick = 0;
  logic i_lfo_tick = 0;
  logic i_mult_tick = 0;
  logic i_usb_activity = 0;
  logic i_vbus_level = 0;
  logic i_bus_power_polarity_select = 1;
  logic [7:0] o_sfr_rdata, o_low_freq_osc_control, o_multiplier_control;
  logic [6:0] o_period_trim;
  logic o_int_osc_run, o_system_clock_tick, o_usb_bus_clock_tick, o_switch_busy;
  logic [7:0] rd_val, r;
  int cyc = 0;
  int err_total = 0;
  int num_checks = 0;
  int gap;
  int trim_q[$];

  oscsel_top #(.FACTORY_TRIM(TRIM)) i_dut (.i_clk(i_clk), .i_srst(i_srst), .i_sfr_wr(i_sfr_wr),
    .i_sfr_rd(i_sfr_rd), .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata),
    .i_int_osc_tick(i_int_osc_tick), .i_ext_clk_tick(i_ext_clk_tick), .i_lfo_tick(i_lfo_tick),
    .i_mult_tick(i_mult_tick), .i_usb_activity(i_usb_activity), .i_vbus_level(i_vbus_level),
    .i_bus_power_polarity_select(i_bus_power_polarity_select), .o_int_osc_run(o_int_osc_run),
    .o_period_trim(o_period_trim), .o_low_freq_osc_control(o_low_freq_osc_control),
    .o_multiplier_control(o_multiplier_control), .o_system_clock_tick(o_system_clock_tick),
    .o_usb_bus_clock_tick(o_usb_bus_clock_tick), .o_switch_busy(o_switch_busy));

  initial begin
    forever #50 i_clk = ~i_clk;
  end

  // free-running raw sources; distinct periods make each selection visible
  always @(negedge i_clk) begin
    cyc <= cyc + 1;
    i_int_osc_tick <= (cyc % 2 == 0);
    i_ext_clk_tick <= (cyc % 3 == 0);
    i_lfo_tick <= (cyc % 7 == 0);
    i_mult_tick <= (cyc % 5 == 0);
    if (cyc > LIMIT) begin
      err_total++;
      give_verdict();
    end
  end

  function automatic int exp_sys(input int s, input int d);
    case (s)
      0: return 2 * (1 << d);
      1: return 3;
      2: return 10;
      default: return 7;
    endcase
  endfunction

  function automatic int exp_usb(input int u);
    return (u == 0) ? 5 : (u == 1) ? 3 : 4;
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    i_sfr_wr = 1;
    i_sfr_addr = a;
    i_sfr_wdata = d;
    @(negedge i_clk);
    i_sfr_wr = 0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge i_clk);
    i_sfr_rd = 1;
    i_sfr_addr = a;
    @(negedge i_clk);
    i_sfr_rd = 0;
    @(negedge i_clk);
    rd_val = o_sfr_rdata;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  // cycles between two consecutive output ticks, bounded
  task automatic measure(input bit usb, output int g);
    int k;
    k = 0;
    while ((usb ? o_usb_bus_clock_tick : o_system_clock_tick) !== 1'b1 && k < 200) begin
      @(negedge i_clk);
      k++;
    end
    g = 0;
    do begin
      @(negedge i_clk);
      g++;
    end while ((usb ? o_usb_bus_clock_tick : o_system_clock_tick) !== 1'b1 && g < 200);
  endtask

  task automatic do_reset();
    @(negedge i_clk);
    i_srst = 1;
    idle(16);
    i_srst = 0;
    trim_q.delete();
    idle(10);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    r = 8'($urandom(46));
    do_reset();
    rd(ADDR_OSC_CONTROL);
    check(rd_val & 8'hC0, RST_OSC_CONTROL & 8'hC0);
    check({1'b0, o_period_trim}, {1'b0, TRIM});
    measure(0, gap);
    check(gap[7:0], 8'(exp_sys(0, 3)));
    rd(8'h00);
    check(rd_val, 8'h00);
    $display("test reset done");
    for (int d = 3; d >= 0; d--) begin
      wr(ADDR_OSC_CONTROL, 8'h80 | d[7:0]);
      idle(30);
      measure(0, gap);
      check(gap[7:0], 8'(exp_sys(0, d)));
    end
    $display("test divider done");
    // low-freq source still disabled: switch must wait with busy raised
    wr(ADDR_CLK_SELECT, 8'h03);
    idle(10);
    check({7'h0, o_switch_busy}, 8'h01);
    wr(ADDR_LFO_CONTROL, 8'h80);
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_CLK_SELECT, s[7:0]);
      idle(40);
      measure(0, gap);
      check(gap[7:0], 8'(exp_sys(s, 0)));
    end
    check({7'h0, o_switch_busy}, 8'h00);
    // multiplier must be locked before it can feed the usb clock
    wr(ADDR_MULT_CONTROL, MULT_INIT_BITS);
    idle(3);
    check(o_multiplier_control, MULT_INIT_BITS);
    for (int u = 0; u < 3; u++) begin
      wr(ADDR_CLK_SELECT, {2'b00, u[1:0], 4'h0});
      idle(40);
      measure(1, gap);
      check(gap[7:0], 8'(exp_usb(u)));
    end
    rd(ADDR_MULT_CONTROL);
    check(rd_val, MULT_INIT_BITS | 8'h20);
    // usb source code 3 is off: measure runs to its bound of 200
    wr(ADDR_CLK_SELECT, 8'h30);
    idle(4);
    measure(1, gap);
    check(gap[7:0], 8'hC8);
    // usb source moved off the internal oscillator before trimming it
    wr(ADDR_CLK_SELECT, 8'h00);
    $display("test sources done");
    r = 8'($urandom) & 8'h7F;
    wr(ADDR_OSC_CALIBRATION, r);
    trim_q.push_back(r);
    idle(3);
    check({1'b0, o_period_trim}, 8'(trim_q[$]));
    rd(ADDR_OSC_CALIBRATION);
    check(rd_val & 8'h7F, 8'(trim_q[$]));
    r = 8'($urandom);
    wr(ADDR_LFO_CONTROL, r);
    idle(3);
    check(o_low_freq_osc_control, r);
    rd(ADDR_LFO_CONTROL);
    check(rd_val, r);
    do_reset();
    check({1'b0, o_period_trim}, {1'b0, TRIM});
    rd(ADDR_OSC_CALIBRATION);
    check(rd_val & 8'h7F, {1'b0, TRIM});
    $display("test trim done");
    wr(ADDR_OSC_CONTROL, 8'h03);
    idle(4);
    check({7'h0, o_int_osc_run}, 8'h00);
    wr(ADDR_OSC_CONTROL, 8'h83);
    idle(10);
    check({7'h0, o_int_osc_run}, 8'h01);
    rd(ADDR_OSC_CONTROL);
    check(rd_val & 8'hC0, 8'hC0);
    for (int w = 0; w < 2; w++) begin
      wr(ADDR_OSC_CONTROL, 8'hA3);
      idle(6);
      check({7'h0, o_int_osc_run}, 8'h00);
      rd(ADDR_OSC_CONTROL);
      check(rd_val & 8'h60, 8'h00);
      // usb activity stands for a transceiver left awake
      if (w == 0)
        i_vbus_level = 1;
      else
        i_usb_activity = 1;
      idle(12);
      check({7'h0, o_int_osc_run}, 8'h01);
      i_vbus_level = 0;
      i_usb_activity = 0;
      idle(4);
    end
    $display("test suspend done");
    give_verdict();
  end
endmodule
